// >>> hw/tpsc_cfg.svh
// offsets, field positions and reset values of the touch power control
`ifndef TPSC_CFG_SVH
`define TPSC_CFG_SVH
`define TPSC_ADDR_W        8
`define TPSC_OFF_CTRL      8'h00
`define TPSC_OFF_ACT_EN    8'h04
`define TPSC_OFF_STANDBY_SELECT_BIT_EN   8'h08
`define TPSC_OFF_ACT_CFG   8'h0c
`define TPSC_OFF_STANDBY_SELECT_BIT_CFG  8'h10
`define TPSC_OFF_STANDBY_SELECT_BIT_THR  8'h14
`define TPSC_OFF_PATTERN   8'h18
`define TPSC_OFF_SENSE     8'h1c
`define TPSC_OFF_INT_STAT  8'h20
`define TPSC_OFF_INT_CLR   8'h24
`define TPSC_OFF_INT_EN    8'h28
`define TPSC_OFF_STATE     8'h2c
`define TPSC_OFF_RECAL     8'h30
`define TPSC_OFF_THR0      8'h40
`define TPSC_CTRL_STANDBY_SELECT_BIT     0
`define TPSC_CTRL_COMBO    1
`define TPSC_CTRL_DEEP     2
`define TPSC_NCH           6
`define TPSC_PAT_BIT       6
`define TPSC_NINT          7
`define TPSC_CFG_W         14
`define TPSC_SENS_LSB      0
`define TPSC_AVG_LSB       6
`define TPSC_CYC_LSB       4
`define TPSC_GAIN_LSB      12
`define TPSC_RST_EN        6'h3f
`define TPSC_RST_STANDBY_SELECT_BIT_EN   6'h00
`define TPSC_RST_CFG       14'h0000
`define TPSC_RST_THR       8'h40
`define TPSC_PTR_TOP       8'hff
`define TPSC_PTR_BOTTOM    8'h00
`endif

// >>> hw/tpsc_pkg.sv
// types shared by the touch power control block
package tpsc_pkg;
    typedef enum logic [1:0] {
        PS_ACTIVE,
        PS_STANDBY,
        PS_COMBO,
        PS_DEEP
    } tpsc_pstate_type;

    typedef struct packed {
        logic [2:0] chan;
        logic [3:0] sens;
        logic [5:0] avg;
        logic [1:0] cycle;
        logic [1:0] gain;
        logic       recal;
    } tpsc_sense_type;

    typedef struct packed {
        logic       valid;
        logic [2:0] chan;
        logic [7:0] delta;
    } tpsc_meas_type;
endpackage : tpsc_pkg

// >>> hw/tpsc_power_ctrl.sv
// power state, sensing configuration and touch status of the touch controller
//
// Design decisions made here: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`include "tpsc_cfg.svh"

// Notes on behaviour
// (R01) one of four power states from control
// (R02) state change clears touches of dropped channels
// (R03) active state polls active-enabled inputs only
// (R04) standby polls standby inputs, irq stays
// (R05) combo polls active and standby inputs
// (R06) deep sleep polls nothing
// (R07) link traffic wakes without clearing sleep bit
// (R08) clearing sleep bit returns to active
// (R09) active settings, per-channel thresholds
// (R10) standby settings, one shared threshold
// (R11) combo: active settings win when both
// (R12) combo cycle time from low power field
// (R13) combo gain for standby-only inputs
// (R14) status readable, interrupt on touch
// (R15) six channels, each with recalibration enable
// (R16) pattern match sets status and interrupt
// (R17) block write pointer increments, wraps to zero
// (R18) deep beats combo beats standby
module tpsc_power_ctrl (
    input  wire logic                   clock,
    input  wire logic                   arst_n,
    input  wire logic                   hsel,
    input  wire logic [31:0]            haddr,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic [2:0]             hsize,
    input  wire logic [31:0]            hwdata,
    input  wire logic                   hready,
    output logic                        hreadyout,
    output logic                        hresp,
    output logic [31:0]                 hrdata,
    input  wire tpsc_pkg::tpsc_meas_type meas,
    input  wire logic                   linkActive,
    input  wire logic                   linkPtrLoad,
    input  wire logic                   linkDataStrobe,
    input  wire logic [7:0]             linkByte,
    output tpsc_pkg::tpsc_sense_type    senseCfg,
    output logic                        pollReq,
    output logic [5:0]                  touchStatus,
    output logic                        deviceAwake,
    output logic [7:0]                  regPointer,
    output logic                        irq
);
    tpsc_pkg::tpsc_pstate_type pstate_reg, pstate_next;
    tpsc_pkg::tpsc_sense_type  senseCfg_reg, senseCfg_next;
    logic [2:0]                ctrl_reg;
    logic [5:0]                actEn_reg, stbyEn_reg, pattern_reg, recal_reg;
    logic [13:0]               actCfg_reg, stbyCfg_reg;
    logic [7:0]                stbyThr_reg;
    logic [7:0]                chThr_reg [`TPSC_NCH];
    logic [5:0]                sense_reg, sense_next;
    logic [6:0]                intStat_reg, intEn_reg, intSet;
    logic                      irq_reg, awake_reg, pollReq_reg;
    logic [2:0]                pollChan_reg, pollChan_next;
    logic [7:0]                ptr_reg;
    logic [5:0]                monitor;
    logic                      pending_reg, pendWrite_reg, readyOut_reg;
    logic [7:0]                pendAddr_reg;
    logic [31:0]               rdata_reg;
    logic                      wrStrobe, touched;
    logic [7:0]                thr;

    // the monitored set follows the state; deep sleep polls nothing
    function automatic logic [5:0] maskFor(
        input tpsc_pkg::tpsc_pstate_type s,
        input logic [5:0] a,
        input logic [5:0] b);
        case (s)
            tpsc_pkg::PS_ACTIVE:  maskFor = a;        // R03
            tpsc_pkg::PS_STANDBY: maskFor = b;        // R04
            tpsc_pkg::PS_COMBO:   maskFor = a | b;    // R05
            default:              maskFor = 6'h00;    // R06
        endcase
    endfunction : maskFor

    // true when the channel runs on the active settings
    function automatic logic useActive(
        input tpsc_pkg::tpsc_pstate_type s,
        input logic [5:0] a,
        input logic [2:0] c);
        useActive = (s == tpsc_pkg::PS_ACTIVE) ||
                    (s == tpsc_pkg::PS_COMBO && a[c]);   // R11
    endfunction : useActive

    // next enabled channel after c, circularly; c itself if none other
    function automatic logic [2:0] nextChan(
        input logic [5:0] m,
        input logic [2:0] c);
        int k;
        nextChan = c;
        for (int i = `TPSC_NCH; i >= 1; i--) begin
            k = (int'(c) + i) % `TPSC_NCH;
            if (m[k]) begin
                nextChan = 3'(k);
            end
        end
    endfunction : nextChan

    // ---------------- bus slave: one wait state per transfer -------------
    assign wrStrobe = pending_reg && pendWrite_reg;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pending_reg   <= 1'b0;
            pendWrite_reg <= 1'b0;
            pendAddr_reg  <= 8'h00;
            readyOut_reg  <= 1'b1;
        end else if (pending_reg) begin
            pending_reg  <= 1'b0;
            readyOut_reg <= 1'b1;
        end else if (hsel && htrans[1] && hready) begin
            pending_reg   <= 1'b1;
            pendWrite_reg <= hwrite;
            pendAddr_reg  <= haddr[`TPSC_ADDR_W-1:0];
            readyOut_reg  <= 1'b0;
        end
    end

    // read data is built after any earlier write has landed
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rdata_reg <= 32'h0000_0000;
        end else if (pending_reg && !pendWrite_reg) begin
            rdata_reg <= 32'h0000_0000;
            case (pendAddr_reg)
                `TPSC_OFF_CTRL:     rdata_reg[2:0]  <= ctrl_reg;
                `TPSC_OFF_ACT_EN:   rdata_reg[5:0]  <= actEn_reg;
                `TPSC_OFF_STANDBY_SELECT_BIT_EN:  rdata_reg[5:0]  <= stbyEn_reg;
                `TPSC_OFF_ACT_CFG:  rdata_reg[13:0] <= actCfg_reg;
                `TPSC_OFF_STANDBY_SELECT_BIT_CFG: rdata_reg[13:0] <= stbyCfg_reg;
                `TPSC_OFF_STANDBY_SELECT_BIT_THR: rdata_reg[7:0]  <= stbyThr_reg;
                `TPSC_OFF_PATTERN:  rdata_reg[5:0]  <= pattern_reg;
                `TPSC_OFF_SENSE:    rdata_reg[5:0]  <= sense_reg;  // R14
                `TPSC_OFF_INT_STAT: rdata_reg[6:0]  <= intStat_reg;
                `TPSC_OFF_INT_EN:   rdata_reg[6:0]  <= intEn_reg;
                `TPSC_OFF_STATE:    rdata_reg[2:0]  <= {awake_reg, pstate_reg};
                `TPSC_OFF_RECAL:    rdata_reg[5:0]  <= recal_reg;
                default: begin
                    for (int i = 0; i < `TPSC_NCH; i++) begin
                        if (pendAddr_reg == `TPSC_OFF_THR0 + 8'(4 * i)) begin
                            rdata_reg[7:0] <= chThr_reg[i];
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_reg    <= 3'h0;
            actEn_reg   <= `TPSC_RST_EN;
            stbyEn_reg  <= `TPSC_RST_STANDBY_SELECT_BIT_EN;
            actCfg_reg  <= `TPSC_RST_CFG;
            stbyCfg_reg <= `TPSC_RST_CFG;
            stbyThr_reg <= `TPSC_RST_THR;
            pattern_reg <= 6'h00;
            intEn_reg   <= 7'h00;
            recal_reg   <= 6'h00;               // R15
        end else if (wrStrobe) begin
            case (pendAddr_reg)
                `TPSC_OFF_CTRL:     ctrl_reg    <= hwdata[2:0];
                `TPSC_OFF_ACT_EN:   actEn_reg   <= hwdata[5:0];
                `TPSC_OFF_STANDBY_SELECT_BIT_EN:  stbyEn_reg  <= hwdata[5:0];
                `TPSC_OFF_ACT_CFG:  actCfg_reg  <= hwdata[13:0];
                `TPSC_OFF_STANDBY_SELECT_BIT_CFG: stbyCfg_reg <= hwdata[13:0];
                `TPSC_OFF_STANDBY_SELECT_BIT_THR: stbyThr_reg <= hwdata[7:0];
                `TPSC_OFF_PATTERN:  pattern_reg <= hwdata[5:0];
                `TPSC_OFF_INT_EN:   intEn_reg   <= hwdata[6:0];
                `TPSC_OFF_RECAL:    recal_reg   <= hwdata[5:0];
                default: ;
            endcase
        end
    end

    generate
        for (genvar g = 0; g < `TPSC_NCH; g++) begin : gThr
            always_ff @(posedge clock or negedge arst_n) begin
                if (!arst_n) begin
                    chThr_reg[g] <= `TPSC_RST_THR;
                end else if (wrStrobe &&
                             pendAddr_reg == `TPSC_OFF_THR0 + 8'(4 * g)) begin
                    chThr_reg[g] <= hwdata[7:0];
                end
            end
        end
    endgenerate

    // ---------------- power state ----------------------------------------
    always_comb begin
        if (ctrl_reg[`TPSC_CTRL_DEEP]) begin
            pstate_next = tpsc_pkg::PS_DEEP;           // R18
        end else if (ctrl_reg[`TPSC_CTRL_COMBO]) begin
            pstate_next = tpsc_pkg::PS_COMBO;          // R18
        end else if (ctrl_reg[`TPSC_CTRL_STANDBY_SELECT_BIT]) begin
            pstate_next = tpsc_pkg::PS_STANDBY;
        end else begin
            pstate_next = tpsc_pkg::PS_ACTIVE;         // R08
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pstate_reg <= tpsc_pkg::PS_ACTIVE;
        end else begin
            pstate_reg <= pstate_next;                 // R01
        end
    end

    // sensing stays off while the link holds deep sleep awake; only the link side is woken
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            awake_reg <= 1'b1;
        end else begin
            awake_reg <= (pstate_reg != tpsc_pkg::PS_DEEP) ||
                         linkActive;                          // R07
        end
    end

    assign monitor = maskFor(pstate_reg, actEn_reg, stbyEn_reg);

    // ---------------- polling sequencer ----------------------------------
    always_comb begin
        pollChan_next = pollChan_reg;
        if (!monitor[pollChan_reg] ||
            (meas.valid && meas.chan == pollChan_reg)) begin
            pollChan_next = nextChan(monitor, pollChan_reg);
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pollChan_reg <= 3'h0;
            pollReq_reg  <= 1'b0;
        end else begin
            pollChan_reg <= pollChan_next;
            pollReq_reg  <= monitor[pollChan_next];    // R03 R04 R05 R06
        end
    end

    // settings for the channel about to be polled
    always_comb begin
        logic act;
        act = useActive(pstate_reg, actEn_reg, pollChan_next);
        senseCfg_next.chan  = pollChan_next;
        senseCfg_next.recal = recal_reg[pollChan_next];            // R15
        senseCfg_next.sens  = act ? actCfg_reg[`TPSC_SENS_LSB +: 4] :
                              stbyCfg_reg[`TPSC_SENS_LSB +: 4];
        senseCfg_next.avg   = act ? actCfg_reg[`TPSC_AVG_LSB +: 6] :
                              stbyCfg_reg[`TPSC_AVG_LSB +: 6];   // R09 R10
        senseCfg_next.cycle = (pstate_reg == tpsc_pkg::PS_ACTIVE) ?
                              actCfg_reg[`TPSC_CYC_LSB +: 2] :
                              stbyCfg_reg[`TPSC_CYC_LSB +: 2];     // R12
        senseCfg_next.gain  = (pstate_reg == tpsc_pkg::PS_COMBO && !act) ?
                              stbyCfg_reg[`TPSC_GAIN_LSB +: 2] :
                              actCfg_reg[`TPSC_GAIN_LSB +: 2];     // R13
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            senseCfg_reg <= '0;
        end else begin
            senseCfg_reg <= senseCfg_next;
        end
    end

    // ---------------- touch detection ------------------------------------
    assign thr = useActive(pstate_reg, actEn_reg, meas.chan) ?
                 chThr_reg[meas.chan] : stbyThr_reg;                // R09 R10
    assign touched = meas.delta > thr;

    always_comb begin
        sense_next = sense_reg;
        if (meas.valid && monitor[meas.chan]) begin
            sense_next[meas.chan] = touched;
        end
        if (pstate_next != pstate_reg) begin
            // channels dropped by the new state lose their touch
            sense_next = sense_next &
                         maskFor(pstate_next, actEn_reg, stbyEn_reg); // R02
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sense_reg <= 6'h00;
        end else begin
            sense_reg <= sense_next;
        end
    end

    // ---------------- interrupts ------------------------------------------
    always_comb begin
        intSet = {1'b0, sense_next & ~sense_reg};                  // R14
        // an empty pattern never matches
        intSet[`TPSC_PAT_BIT] =
            (pattern_reg != 6'h00) &&
            ((sense_next & pattern_reg) == pattern_reg) &&
            ((sense_reg & pattern_reg) != pattern_reg);             // R16
    end

    // set wins over a clear written in the same cycle
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            intStat_reg <= 7'h00;
        end else if (wrStrobe && pendAddr_reg == `TPSC_OFF_INT_CLR) begin
            intStat_reg <= (intStat_reg & ~hwdata[6:0]) | intSet;
        end else begin
            intStat_reg <= intStat_reg | intSet;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(intStat_reg & intEn_reg);                  // R14
        end
    end

    // ---------------- block write pointer ----------------------------------
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ptr_reg <= `TPSC_PTR_BOTTOM;
        end else if (linkPtrLoad) begin
            ptr_reg <= linkByte;
        end else if (linkDataStrobe) begin
            ptr_reg <= (ptr_reg == `TPSC_PTR_TOP) ?
                       `TPSC_PTR_BOTTOM : ptr_reg + 8'h01;          // R17
        end
    end

    assign hreadyout   = readyOut_reg;
    assign hresp       = 1'b0;
    assign hrdata      = rdata_reg;
    assign senseCfg    = senseCfg_reg;
    assign pollReq     = pollReq_reg;
    assign touchStatus = sense_reg;
    assign deviceAwake = awake_reg;
    assign regPointer  = ptr_reg;
    assign irq         = irq_reg;

    // ---------------- assertions --------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    sequence sDeepHeld;
        pstate_reg == tpsc_pkg::PS_DEEP [*2];
    endsequence

    a_deep_no_poll: assert property (sDeepHeld |-> !pollReq_reg) // R06
        else $error("polling while in deep sleep");
    a_state_priority: assert property ( // R18
        ctrl_reg[`TPSC_CTRL_DEEP] |=> pstate_reg == tpsc_pkg::PS_DEEP)
        else $error("deep sleep bit did not win");
    a_leave_sleep: assert property ( // R08
        ctrl_reg == 3'h0 |=> pstate_reg == tpsc_pkg::PS_ACTIVE)
        else $error("did not return to active");
    // the host may still clear the sleep bit during traffic; only the
    // link itself must leave it alone
    a_wake_on_link: assert property ( // R07
        pstate_reg == tpsc_pkg::PS_DEEP && linkActive && $stable(ctrl_reg) &&
        !(wrStrobe && pendAddr_reg == `TPSC_OFF_CTRL)
        |=> awake_reg && ctrl_reg[`TPSC_CTRL_DEEP])
        else $error("link traffic did not wake or cleared sleep bit");
    a_poll_enabled: assert property ( // R03
        pollReq_reg && $stable(monitor) |-> monitor[senseCfg_reg.chan])
        else $error("polling a channel outside the state mask");
    a_clear_dropped: assert property ( // R02
        pstate_next != pstate_reg |=> (sense_reg & ~monitor) == 6'h00)
        else $error("touch kept on deactivated channel");
    a_combo_cycle: assert property ( // R12
        pstate_reg == tpsc_pkg::PS_COMBO && $stable(pstate_reg)
        ##1 $stable(stbyCfg_reg)
        |-> senseCfg_reg.cycle == stbyCfg_reg[`TPSC_CYC_LSB +: 2])
        else $error("combo cycle time not from low power field");
    // the enable that counts is the one the irq flop saw
    a_pattern_irq: assert property ( // R16
        intSet[`TPSC_PAT_BIT] |=> intStat_reg[`TPSC_PAT_BIT]
        ##1 (irq_reg || !$past(intEn_reg[`TPSC_PAT_BIT])))
        else $error("pattern match not flagged");
    a_irq_level: assert property (|(intStat_reg & intEn_reg) |=> irq_reg) // R14
        else $error("interrupt not raised for enabled status");
    a_ptr_wrap: assert property ( // R17
        !linkPtrLoad && linkDataStrobe && ptr_reg == `TPSC_PTR_TOP
        |=> ptr_reg == `TPSC_PTR_BOTTOM)
        else $error("pointer did not wrap to zero");
endmodule : tpsc_power_ctrl

// >>> verif/tb_touch_power_state_control.sv
// self-checking bench of the touch power state control block
`timescale 1ns/1ps
`include "tpsc_cfg.svh"
module tb_touch_power_state_control;
    logic                     clock = 1'b0;
    logic                     arst_n = 1'b0;
    logic                     hsel = 1'b0;
    logic [31:0]              haddr = 32'h0;
    logic [1:0]               htrans = 2'h0;
    logic                     hwrite = 1'b0;
    logic [2:0]               hsize = 3'h2;
    logic [31:0]              hwdata = 32'h0;
    logic                     hreadyout;
    logic                     hresp;
    logic [31:0]              hrdata;
    tpsc_pkg::tpsc_meas_type  meas = '0;
    tpsc_pkg::tpsc_sense_type senseCfg;
    logic                     linkActive, linkPtrLoad, linkDataStrobe;
    logic [7:0]               linkByte, regPointer, d;
    logic                     pollReq, deviceAwake, irq, stb = 1'b0;
    logic [5:0]               touchStatus;
    logic [31:0]              obs = 32'h0, ex;
    logic [31:0]              q[$];
    int                       n_errors = 0;
    int                       total_checks = 0;
    int                       st;

    always #12.5 clock = ~clock;

    tpsc_power_ctrl dut_u (.clock(clock), .arst_n(arst_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .meas(meas),
        .linkActive(linkActive), .linkPtrLoad(linkPtrLoad),
        .linkDataStrobe(linkDataStrobe), .linkByte(linkByte),
        .senseCfg(senseCfg), .pollReq(pollReq), .touchStatus(touchStatus),
        .deviceAwake(deviceAwake), .regPointer(regPointer), .irq(irq));

    tpsc_host_link host_u (.clock(clock), .linkActive(linkActive),
        .linkPtrLoad(linkPtrLoad), .linkDataStrobe(linkDataStrobe),
        .linkByte(linkByte));

    // results are compared in arrival order against the oldest note
    always @(posedge clock) begin
        if (stb) begin
            ex = q.pop_front();
            total_checks++;
            if (obs !== ex) begin
                n_errors++;
                $display("[FAIL] t=%0t exp=%h got=%h", $time, ex, obs);
            end
        end
    end

    task report_and_stop;
        $display("checks=%0d errors=%0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : report_and_stop

    task note(input logic [31:0] e, input logic [31:0] v);
        q.push_back(e);
        obs <= v;
        stb <= 1'b1;
        @(posedge clock);
        stb <= 1'b0;
        @(posedge clock);
    endtask : note

    task bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
             output logic [31:0] r);
        @(posedge clock);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= w;
        do @(posedge clock); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clock); while (hreadyout !== 1'b1);
        r = hrdata;
        // data phase is over, stale write data must not look valid
        hwdata <= ~wd;
    endtask : bus

    task wr(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] r;
        bus(1'b1, a, v, r);
    endtask : wr

    task rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        note(e, r);
    endtask : rd

    task touch(input logic [2:0] c, input logic [7:0] dl);
        @(posedge clock);
        meas <= '{1'b1, c, dl};
        @(posedge clock);
        meas <= '{1'b0, ~c, ~dl};
        repeat (2) @(posedge clock);
    endtask : touch

    task ts(input logic [5:0] e);
        note({26'h0, e}, {26'h0, touchStatus});
    endtask : ts

    // pollReq, channel, gain, cycle and recal of the poll in hand
    task sc(input logic [8:0] e);
        note({23'h0, e}, {23'h0, pollReq, senseCfg.chan, senseCfg.gain,
                          senseCfg.cycle, senseCfg.recal});
    endtask : sc

    initial begin
        repeat (20000) @(posedge clock);
        n_errors++;
        report_and_stop();
    end

    initial begin
        void'($urandom(32'h9525a9d7));
        repeat (16) @(posedge clock);
        arst_n <= 1'b1;
        rd(`TPSC_OFF_CTRL, 32'h0);
        note(32'h0, {31'h0, hresp});
        rd(`TPSC_OFF_ACT_EN, 32'h3f);
        rd(`TPSC_OFF_STANDBY_SELECT_BIT_EN, 32'h0);
        rd(`TPSC_OFF_STANDBY_SELECT_BIT_THR, 32'h40);
        rd(8'h3c, 32'h0);
        rd(`TPSC_OFF_INT_CLR, 32'h0);
        for (int i = 0; i < 6; i++)
            rd(`TPSC_OFF_THR0 + 8'(4 * i), 32'h40);
        for (int c = 0; c < 8; c++) begin
            wr(`TPSC_OFF_CTRL, c);
            st = c[2] ? 3 : c[1] ? 2 : c[0] ? 1 : 0;
            rd(`TPSC_OFF_STATE, {29'h0, ~c[2], 2'(st)});
        end
        wr(`TPSC_OFF_CTRL, 32'h0);
        wr(`TPSC_OFF_INT_EN, 32'h7f);
        wr(`TPSC_OFF_PATTERN, 32'h01);
        touch(3'h0, 8'h40);
        ts(6'h00);
        d = 8'h41 + 8'($urandom % 191);
        touch(3'h0, d);
        ts(6'h01);
        note(32'h1, {31'h0, irq});
        rd(`TPSC_OFF_INT_STAT, 32'h41);
        wr(`TPSC_OFF_INT_CLR, 32'h7f);
        // the irq flop follows the cleared status one edge later
        repeat (2) @(posedge clock);
        note(32'h0, {31'h0, irq});
        wr(`TPSC_OFF_THR0 + 8'h4, 32'hf0);
        wr(`TPSC_OFF_STANDBY_SELECT_BIT_EN, 32'h02);
        wr(`TPSC_OFF_CTRL, 32'h1);
        // state follows the control bits one edge late, touches clear on the same edge
        repeat (2) @(posedge clock);
        ts(6'h00);
        touch(3'h1, 8'h41);
        ts(6'h02);
        touch(3'h0, 8'hff);
        ts(6'h02);
        wr(`TPSC_OFF_CTRL, 32'h0);
        wr(`TPSC_OFF_THR0, 32'hf0);
        wr(`TPSC_OFF_ACT_EN, 32'h01);
        wr(`TPSC_OFF_STANDBY_SELECT_BIT_EN, 32'h03);
        // active gain 1, cycle 1; low power gain 2, cycle 2
        wr(`TPSC_OFF_ACT_CFG, 32'h1010);
        wr(`TPSC_OFF_STANDBY_SELECT_BIT_CFG, 32'h2020);
        wr(`TPSC_OFF_RECAL, 32'h02);
        wr(`TPSC_OFF_CTRL, 32'h2);
        touch(3'h0, 8'h41);
        note(32'h0, {31'h0, touchStatus[0]});
        sc({1'b1, 3'h1, 2'h2, 2'h2, 1'b1});
        touch(3'h1, 8'h00);
        sc({1'b1, 3'h0, 2'h1, 2'h2, 1'b0});
        wr(`TPSC_OFF_CTRL, 32'h4);
        repeat (4) @(posedge clock);
        note(32'h0, {30'h0, deviceAwake, pollReq});
        host_u.frame(1'b1);
        repeat (2) @(posedge clock);
        note(32'h1, {31'h0, deviceAwake});
        host_u.load(8'hfe);
        repeat (2) @(posedge clock);
        note(32'hfe, {24'h0, regPointer});
        host_u.data_byte();
        repeat (2) @(posedge clock);
        note(32'hff, {24'h0, regPointer});
        host_u.data_byte();
        repeat (2) @(posedge clock);
        note(32'h00, {24'h0, regPointer});
        host_u.frame(1'b0);
        repeat (2) @(posedge clock);
        note(32'h0, {31'h0, deviceAwake});
        rd(`TPSC_OFF_CTRL, 32'h4);
        wr(`TPSC_OFF_CTRL, 32'h0);
        rd(`TPSC_OFF_STATE, 32'h4);
        repeat (4) @(posedge clock);
        report_and_stop();
    end
endmodule : tb_touch_power_state_control

// >>> verif/tpsc_host_link.sv
// host end of the serial link: framing, pointer loads and data bytes
`timescale 1ns/1ps
module tpsc_host_link (
    input  wire logic clock,
    output logic      linkActive,
    output logic      linkPtrLoad,
    output logic      linkDataStrobe,
    output logic [7:0] linkByte
);
    initial begin
        linkActive     = 1'b0;
        linkPtrLoad    = 1'b0;
        linkDataStrobe = 1'b0;
        linkByte       = 8'h5a;
    end

    task frame(input logic on);
        @(posedge clock);
        linkActive <= on;
    endtask : frame

    task load(input logic [7:0] p);
        @(posedge clock);
        linkPtrLoad <= 1'b1;
        linkByte    <= p;
        @(posedge clock);
        linkPtrLoad <= 1'b0;
        // byte is meaningless once the load strobe drops
        linkByte    <= ~p;
    endtask : load

    task data_byte;
        @(posedge clock);
        linkDataStrobe <= 1'b1;
        @(posedge clock);
        linkDataStrobe <= 1'b0;
    endtask : data_byte
endmodule : tpsc_host_link
